// ---- design/tefm_top.sv ----
// Timer event flags, interrupt enables and request logic with AHB-Lite slave
//
// Contract
// - Flags: 16-bit register, word or byte access
// - Flag with set enable raises interrupt request
// - Compare flag set on counter match
// - Capture flag set on selected pin edge
// - Shared flag: capture edge or compare-5 match
// - Counter wrap flag on all-ones to zero
// - Accumulator wrap flag on FF to 00
// - Event mode: active accumulator edge sets flag
// - Gated mode: gate end sets flag
// - No interrupt while enable bit clear
// - Flags set regardless of enable bits
// - Enables: 16-bit, byte access, reset zero
// - Low enable bits drive prescaler select
// - Shared enable follows shared pin function
// - Clear by read-set then write zero
// - Request at programmed level; zero disables
`timescale 1ns/1ps

module tefm_top
  import tefm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire tefm_timer_t i_timer,
  input wire logic [3:0] i_capture_pin,
  input wire logic i_accumulator_input_pin,
  output logic o_irq,
  output logic [2:0] o_request_priority_level,
  output logic [3:0] o_prescaler_select
);

  // Byte lane enables of one access
  function automatic logic [3:0] lanes(input logic [2:0] size,
                                       input logic [1:0] a);
    logic [3:0] l;
    l = 4'hF;
    if (size == TEFM_HSIZE_BYTE)
    begin
      l = 4'h1 << a;
    end
    else if (size == TEFM_HSIZE_HALF)
    begin
      l = a[1] ? 4'hC : 4'h3;
    end
    return l;
  endfunction

  // Edge test against a selection
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev,
                                    input logic cur);
    logic h;
    h = 1'b0;
    unique case (sel)
      TEFM_EDGE_OFF: h = 1'b0;
      TEFM_EDGE_RISE: h = !prev && cur;
      TEFM_EDGE_FALL: h = prev && !cur;
      TEFM_EDGE_ANY: h = prev != cur;
    endcase
    return h;
  endfunction

  // Merge written byte lanes of the low half into a register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] l);
    logic [15:0] m;
    m = old;
    if (l[0])
    begin
      m[7:0] = wd[7:0];
    end
    if (l[1])
    begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  // Register select: mapped word address equal to a register's
  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [9:0] r);
    logic h;
    h = a[31:10] == 22'h0 && {a[9:2], 2'b00} == r;
    return h;
  endfunction

  // Registers
  logic [15:0] flags_ff;
  logic [15:0] enables_ff;
  logic [15:0] config_ff;
  logic [15:0] armed_ff;
  logic [15:0] nxt_flags;
  logic [15:0] nxt_enables;
  logic [15:0] nxt_config;
  logic [15:0] nxt_armed;

  // Bus data phase state and output registers
  logic wr_pend_ff;
  logic [9:0] wr_addr_ff;
  logic [3:0] wr_lanes_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic irq_ff;
  logic [2:0] level_ff;
  logic [3:0] presc_ff;

  // Pin synchronisers and filtered levels
  logic [TEFM_NUM_PINS-1:0] sync1_ff;
  logic [TEFM_NUM_PINS-1:0] sync2_ff;
  logic [TEFM_NUM_PINS-1:0] sync3_ff;
  logic [TEFM_NUM_PINS-1:0] pin_ff;
  logic [TEFM_NUM_PINS-1:0] nxt_pin;

  // Previous timer values for match and wrap detection
  logic [15:0] cnt_prev_ff;
  logic [7:0] acc_prev_ff;

  // Address phase decode
  wire addr_phase = i_hsel && i_hready && i_htrans == TEFM_HTRANS_NONSEQ;
  wire [9:0] req_addr = {i_haddr[9:2], 2'b00};
  wire mapped = i_haddr[31:10] == '0;
  wire sel_flags = reg_hit(i_haddr, TEFM_ADDR_FLAGS);
  wire sel_enables = reg_hit(i_haddr, TEFM_ADDR_ENABLES);
  wire sel_config = reg_hit(i_haddr, TEFM_ADDR_CONFIG);
  wire [3:0] req_lanes = lanes(i_hsize, i_haddr[1:0]);
  wire rd_take = addr_phase && !i_hwrite;
  wire wr_take = addr_phase && i_hwrite;

  // Data phase write selects
  wire wr_flags = wr_pend_ff && wr_addr_ff == TEFM_ADDR_FLAGS;
  wire wr_enables = wr_pend_ff && wr_addr_ff == TEFM_ADDR_ENABLES;
  wire wr_config = wr_pend_ff && wr_addr_ff == TEFM_ADDR_CONFIG;
  wire [15:0] wr_bits = {{8{wr_lanes_ff[1]}}, {8{wr_lanes_ff[0]}}};

  // Config fields
  wire shared_is_cmp = config_ff[TEFM_CFG_SHCMP];
  wire gated_mode = config_ff[TEFM_CFG_GATED];
  wire acc_pol = config_ff[TEFM_CFG_APOL];

  // Filtered pin level: a change counts once stages two and three agree
  assign nxt_pin = (sync2_ff & ~(sync2_ff ^ sync3_ff))
                 | (pin_ff & (sync2_ff ^ sync3_ff));

  // Capture edges on the four capture pins
  logic [3:0] cap_hit;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      cap_hit[i] = edge_hit(config_ff[TEFM_CFG_EDGE_LSB + 2*i +: 2],
                            pin_ff[i], nxt_pin[i]);
    end
  end

  // Compare matches, counted once when the counter arrives at the value
  // A counter that stalls on the value does not set the flag again
  wire cnt_moved = i_timer.counter != cnt_prev_ff;
  logic [4:0] cmp_hit;
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      cmp_hit[i] = cnt_moved
                && i_timer.counter == i_timer.compare[i];
    end
  end

  // Wraps of the free-running counter and the accumulator
  wire cnt_wrap = cnt_prev_ff == TEFM_CNT_MAX
               && i_timer.counter == TEFM_CNT_ZERO;
  wire acc_wrap = acc_prev_ff == TEFM_ACC_MAX
               && i_timer.accum == TEFM_ACC_ZERO;

  // Accumulator input: active edge, or end of the gated period
  wire apin_prev = pin_ff[4];
  wire apin_cur = nxt_pin[4];
  wire acc_edge = !gated_mode && apin_cur == acc_pol
               && apin_prev != acc_pol;
  wire gate_end = gated_mode && apin_prev == acc_pol
               && apin_cur != acc_pol;

  // Shared channel source chosen by the pin function
  wire shared_hit = shared_is_cmp ? cmp_hit[4] : cap_hit[3];

  // Event vector in flag layout, independent of the enables
  logic [15:0] events;
  always_comb
  begin
    events = '0;
    events[TEFM_BIT_SHARED] = shared_hit;
    for (int i = 0; i < TEFM_NUM_CMP; i++)
    begin
      events[TEFM_BIT_CMP1 + i] = cmp_hit[i];
    end
    for (int i = 0; i < TEFM_NUM_CAP; i++)
    begin
      events[TEFM_BIT_CAP1 + i] = cap_hit[i];
    end
    events[TEFM_BIT_CWRAP] = cnt_wrap;
    events[TEFM_BIT_AWRAP] = acc_wrap;
    events[TEFM_BIT_AINP] = acc_edge || gate_end;
  end

  // Flags clear only where armed by a read and written zero
  // An event in the clearing cycle wins and keeps the flag
  wire [15:0] clr_bits = wr_flags ? (armed_ff & wr_bits & ~i_hwdata[15:0])
                                  : 16'h0000;
  assign nxt_flags = ((flags_ff & ~clr_bits) | events)
                   & TEFM_FLAGS_MASK;

  // Read arms set flags; a new event or a clear disarms
  wire [3:0] rd_lanes = rd_take ? req_lanes : 4'h0;
  wire rd_flags = rd_take && sel_flags;
  wire [15:0] rd_bits = rd_flags
                      ? {{8{rd_lanes[1]}}, {8{rd_lanes[0]}}} : 16'h0000;
  assign nxt_armed = ((armed_ff & ~clr_bits & ~events)
                   | (nxt_flags & rd_bits)) & TEFM_FLAGS_MASK;

  // Enables and config take byte-lane writes
  assign nxt_enables = wr_enables
    ? merge(enables_ff, i_hwdata, wr_lanes_ff) & TEFM_ENABLES_MASK
    : enables_ff;
  assign nxt_config = wr_config
    ? merge(config_ff, i_hwdata, wr_lanes_ff) & TEFM_CONFIG_MASK
    : config_ff;

  // Request: any flag with its enable, at a nonzero level
  wire [15:0] pending = nxt_flags & nxt_enables
                      & TEFM_FLAGS_MASK;
  wire [2:0] nxt_lvl = nxt_config[TEFM_CFG_LEVEL_LSB +: 3];
  wire nxt_irq = |pending && nxt_lvl != 3'h0;

  // Read data reflects any write finishing this cycle
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (sel_flags)
    begin
      rd_word = {16'h0000, nxt_flags};
    end
    else if (sel_enables)
    begin
      rd_word = {16'h0000, nxt_enables};
    end
    else if (sel_config)
    begin
      rd_word = {16'h0000, nxt_config};
    end
  end

  // Pin synchronisers
  // Stage one feeds stage two only; it may go metastable
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      pin_ff <= '0;
    end
    else
    begin
      sync1_ff <= {i_accumulator_input_pin, i_capture_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_ff <= nxt_pin;
    end
  end

  // Timer history
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_prev_ff <= TEFM_CNT_ZERO;
      acc_prev_ff <= TEFM_ACC_ZERO;
    end
    else
    begin
      cnt_prev_ff <= i_timer.counter;
      acc_prev_ff <= i_timer.accum;
    end
  end

  // Register state
  // Flags, enables and config all clear together at reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      flags_ff <= TEFM_FLAGS_RST;
      enables_ff <= TEFM_ENABLES_RST;
      config_ff <= TEFM_CONFIG_RST;
      armed_ff <= TEFM_FLAGS_RST;
    end
    else
    begin
      flags_ff <= nxt_flags;
      enables_ff <= nxt_enables;
      config_ff <= nxt_config;
      armed_ff <= nxt_armed;
    end
  end

  // Bus slave: zero wait, always OKAY
  // Never stretches a transfer; reads answer in the next cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      wr_lanes_ff <= '0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= wr_take && mapped;
      wr_addr_ff <= req_addr;
      wr_lanes_ff <= req_lanes;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= rd_take ? rd_word : 32'h0000_0000;
    end
  end

  // Interrupt and prescaler outputs
  // Level output reads zero whenever no request stands
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      irq_ff <= 1'b0;
      level_ff <= 3'h0;
      presc_ff <= 4'h0;
    end
    else
    begin
      irq_ff <= nxt_irq;
      level_ff <= nxt_irq ? nxt_lvl : 3'h0;
      presc_ff <= nxt_enables[TEFM_PRESC_LSB +: TEFM_PRESC_W];
    end
  end

  // Outputs straight from registers
  assign o_hreadyout = hreadyout_ff;
  assign o_hresp = hresp_ff;
  assign o_hrdata = hrdata_ff;
  assign o_irq = irq_ff;
  assign o_request_priority_level = level_ff;
  assign o_prescaler_select = presc_ff;

endmodule // tefm_top

// ---- design/tefm_pkg.sv ----
// Package: register map, field layout and types of the timer event unit
package tefm_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] TEFM_IDX_ENABLES = 8'h20;
  localparam logic [7:0] TEFM_IDX_FLAGS = 8'h22;
  localparam logic [7:0] TEFM_IDX_CONFIG = 8'h24;
  localparam logic [9:0] TEFM_ADDR_ENABLES = {TEFM_IDX_ENABLES, 2'b00};
  localparam logic [9:0] TEFM_ADDR_FLAGS = {TEFM_IDX_FLAGS, 2'b00};
  localparam logic [9:0] TEFM_ADDR_CONFIG = {TEFM_IDX_CONFIG, 2'b00};

  // Reset values
  localparam logic [15:0] TEFM_FLAGS_RST = 16'h0000;
  localparam logic [15:0] TEFM_ENABLES_RST = 16'h0000;
  localparam logic [15:0] TEFM_CONFIG_RST = 16'h0000;

  // Implemented bits of each register
  localparam logic [15:0] TEFM_FLAGS_MASK = 16'hFFB0;
  localparam logic [15:0] TEFM_ENABLES_MASK = 16'hFFBF;
  localparam logic [15:0] TEFM_CONFIG_MASK = 16'h3FFF;

  // Flag and enable bit positions
  localparam int TEFM_BIT_SHARED = 15;
  localparam int TEFM_BIT_CMP1 = 11;
  localparam int TEFM_BIT_CAP1 = 8;
  localparam int TEFM_BIT_CWRAP = 7;
  localparam int TEFM_BIT_AWRAP = 5;
  localparam int TEFM_BIT_AINP = 4;
  localparam int TEFM_NUM_CMP = 4;
  localparam int TEFM_NUM_CAP = 3;

  // Prescaler select field in the enables register
  localparam int TEFM_PRESC_LSB = 0;
  localparam int TEFM_PRESC_W = 4;

  // Config register fields
  localparam int TEFM_CFG_LEVEL_LSB = 0;
  localparam int TEFM_CFG_SHCMP = 3;
  localparam int TEFM_CFG_EDGE_LSB = 4;
  localparam int TEFM_CFG_GATED = 12;
  localparam int TEFM_CFG_APOL = 13;

  // Counter limits
  localparam logic [15:0] TEFM_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TEFM_CNT_ZERO = 16'h0000;
  localparam logic [7:0] TEFM_ACC_MAX = 8'hFF;
  localparam logic [7:0] TEFM_ACC_ZERO = 8'h00;

  // Pin synchroniser depth and pin count
  localparam int TEFM_SYNC_STAGES = 3;
  localparam int TEFM_NUM_PINS = 5;

  // Bus encodings
  localparam logic [1:0] TEFM_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] TEFM_HSIZE_BYTE = 3'b000;
  localparam logic [2:0] TEFM_HSIZE_HALF = 3'b001;

  // Capture edge selections
  typedef enum logic [1:0] {
    TEFM_EDGE_OFF,
    TEFM_EDGE_RISE,
    TEFM_EDGE_FALL,
    TEFM_EDGE_ANY
  } tefm_edge_t;

  // Timer values from the counting logic on the same clock
  typedef struct packed {
    logic [15:0] counter;
    logic [4:0][15:0] compare;
    logic [7:0] accum;
  } tefm_timer_t;

endpackage

// ---- dv/tefm_chk.sv ----
// Checker: bus answer and interrupt output properties
`timescale 1ns/1ps
module tefm_chk
  import tefm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic o_irq,
  input wire logic [2:0] o_request_priority_level,
  input wire logic [3:0] o_prescaler_select
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Taken transfers and word writes to the two control registers
  wire logic tk = i_hsel & i_hready & (i_htrans == TEFM_HTRANS_NONSEQ);
  wire logic tk_rd = tk & !i_hwrite;
  wire logic tk_wr = tk & i_hwrite & (i_hsize == 3'h2);
  wire logic wr_en = tk_wr & (i_haddr == {22'h0, TEFM_ADDR_ENABLES});
  wire logic wr_cf = tk_wr & (i_haddr == {22'h0, TEFM_ADDR_CONFIG});

  property p_okay;
    o_hresp == 1'b0 && o_hreadyout == 1'b1;
  endproperty
  a_okay: assert property (p_okay) else $error("bad bus answer");
  property p_rd_src;
    o_hrdata != 32'h0 |-> $past(tk_rd);
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("stray data");
  property p_rd_hi;
    o_hrdata[31:16] == 16'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper lanes");
  property p_rd_end;
    o_hrdata != 32'h0 && !tk_rd |=> o_hrdata == 32'h0;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("data held");
  property p_presc;
    wr_en ##1 1'b1 |=> ##1 o_prescaler_select == $past(i_hwdata[3:0], 2);
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler");
  property p_en_off;
    wr_en ##1 (i_hwdata[15:4] == 12'h0) |=> ##1 !o_irq;
  endproperty
  a_en_off: assert property (p_en_off) else $error("masked irq");
  property p_lvl_off;
    wr_cf ##1 (i_hwdata[2:0] == 3'h0) |=> ##1
      !o_irq && o_request_priority_level == 3'h0;
  endproperty
  a_lvl_off: assert property (p_lvl_off) else $error("level 0");
  property p_lvl;
    o_irq == (o_request_priority_level != 3'h0);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level vs irq");
  property p_lvl_val;
    wr_cf ##1 1'b1 ##2 o_irq |->
      o_request_priority_level == $past(i_hwdata[2:0], 2);
  endproperty
  a_lvl_val: assert property (p_lvl_val) else $error("level");

  // Main scenarios reached
  c_irq: cover property ($rose(o_irq));
  c_rd: cover property (o_hrdata != 32'h0);
  c_presc: cover property (wr_en);
endmodule // tefm_chk

bind tefm_top tefm_chk u_chk (.i_clk, .i_rst_n, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hreadyout,
  .o_hresp, .o_hrdata, .o_irq, .o_request_priority_level,
  .o_prescaler_select);

// ---- dv/tefm_host.sv ----
// Host model: AHB-Lite master with transfer and flag service tasks
`timescale 1ns/1ps
module tefm_host
  import tefm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata,
  output logic o_rd_vld,
  output logic [31:0] o_rd_data
);
  // Idle bus at time zero
  initial
  begin
    o_haddr = 32'h0;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
    o_rd_vld = 1'b0;
    o_rd_data = 32'h0;
  end

  // One word transfer; read data handed on with a one-cycle valid
  task automatic xfer(input logic wr, input logic [9:0] a,
                      input logic [31:0] d);
    o_haddr <= {22'h0, a};
    o_htrans <= TEFM_HTRANS_NONSEQ;
    o_hwrite <= wr;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_htrans <= 2'b00;
    o_hwdata <= wr ? d : ~o_hwdata;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_rd_vld <= !wr;
    o_rd_data <= i_hrdata;
    @(posedge i_clk);
    o_rd_vld <= 1'b0;
  endtask

  // Service: read arms set flags, zero write clears them
  task automatic service;
    xfer(1'b0, TEFM_ADDR_FLAGS, 32'h0);
    xfer(1'b1, TEFM_ADDR_FLAGS, 32'h0);
  endtask
endmodule // tefm_host

// ---- dv/tb.sv ----
// Testbench: registers, event flags and interrupt request
`timescale 1ns/1ps
module tb import tefm_pkg::*;;
  logic clk;
  logic rst_n;
  logic hready;
  logic irq;
  logic [2:0] lvl;
  logic [3:0] presc;
  logic [3:0] cap;
  logic apin;
  logic rd_vld;
  logic [31:0] rd_data, haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  tefm_timer_t tmr;
  logic [15:0] w;
  logic [31:0] expq[$];
  int n_mismatch = 0;
  int cmp_count = 0;

  tefm_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(1'b1),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(), .o_hrdata(hrdata), .i_timer(tmr),
    .i_capture_pin(cap), .i_accumulator_input_pin(apin), .o_irq(irq),
    .o_request_priority_level(lvl), .o_prescaler_select(presc));
  tefm_host h (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata), .o_rd_vld(rd_vld),
    .o_rd_data(rd_data));

  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out;
  end

  // Read results against the oldest expectation
  always @(posedge clk)
    if (rd_vld === 1'b1)
    begin
      cmp(rd_data, expq.pop_front());
    end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    expq.push_back(e);
    h.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    h.xfer(1'b1, a, d);
  endtask
  task automatic svc(input logic [15:0] e);
    expq.push_back({16'h0, e});
    h.service;
    rd(TEFM_ADDR_FLAGS, 32'h0);
  endtask
  task automatic cnt(input logic [15:0] v);
    tmr.counter <= v;
    @(posedge clk);
  endtask
  task automatic wrap;
    cnt(16'hFFFF);
    cnt(16'h0000);
    cnt(16'h1000);
  endtask
  task automatic pins(input logic [3:0] c, input logic a);
    cap <= c;
    apin <= a;
    repeat (6) @(posedge clk);
  endtask
  task automatic irq_is(input logic e, input logic [2:0] l);
    @(negedge clk);
    cmp({28'h0, irq, lvl}, {28'h0, e, l});
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    cap = 4'h0;
    apin = 1'b0;
    tmr = {16'h1000, {5{16'h5555}}, 8'h10};
    void'($urandom(32'hF77C));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(TEFM_ADDR_ENABLES, 32'h0);
    rd(TEFM_ADDR_FLAGS, 32'h0);
    rd(10'h3FC, 32'h0);
    w = 16'($urandom());
    wr(TEFM_ADDR_ENABLES, {16'h0, w});
    rd(TEFM_ADDR_ENABLES, {16'h0, w & TEFM_ENABLES_MASK});
    cmp({28'h0, presc}, {28'h0, w[3:0]});
    wr(TEFM_ADDR_ENABLES, 32'h0);
    wrap;
    wr(TEFM_ADDR_CONFIG, 32'h8);
    for (int i = 0; i < 5; i++)
    begin
      w = 16'h2000 | 16'($urandom() & 32'hFFF);
      tmr.compare[i] <= w;
      cnt(16'h1000);
      cnt(w);
      cnt(16'h1000);
      tmr.compare[i] <= 16'h5555;
    end
    rd(TEFM_ADDR_FLAGS, 32'hF880);
    svc(16'hF880);
    wrap;
    wr(TEFM_ADDR_FLAGS, 32'h0);
    rd(TEFM_ADDR_FLAGS, 32'h80);
    wrap;
    wr(TEFM_ADDR_FLAGS, 32'h0);
    rd(TEFM_ADDR_FLAGS, 32'h80);
    svc(16'h0080);
    wr(TEFM_ADDR_CONFIG, 32'h790);
    pins(4'hF, 1'b0);
    rd(TEFM_ADDR_FLAGS, 32'h8500);
    pins(4'h0, 1'b0);
    svc(16'h8700);
    tmr.accum <= 8'hFF;
    @(posedge clk);
    tmr.accum <= 8'h00;
    wr(TEFM_ADDR_CONFIG, 32'h2000);
    pins(4'h0, 1'b1);
    svc(16'h0030);
    wr(TEFM_ADDR_CONFIG, 32'h3000);
    pins(4'h0, 1'b0);
    svc(16'h0010);
    pins(4'h0, 1'b1);
    rd(TEFM_ADDR_FLAGS, 32'h0);
    wr(TEFM_ADDR_ENABLES, 32'h80);
    wr(TEFM_ADDR_CONFIG, 32'h5);
    wrap;
    irq_is(1'b1, 3'h5);
    wr(TEFM_ADDR_ENABLES, 32'h0);
    irq_is(1'b0, 3'h0);
    wr(TEFM_ADDR_ENABLES, 32'h80);
    wr(TEFM_ADDR_CONFIG, 32'h0);
    irq_is(1'b0, 3'h0);
    wr(TEFM_ADDR_CONFIG, 32'h7);
    irq_is(1'b1, 3'h7);
    svc(16'h0080);
    irq_is(1'b0, 3'h0);
    wr(TEFM_ADDR_ENABLES, 32'h8000);
    wr(TEFM_ADDR_CONFIG, 32'hF);
    tmr.compare[4] <= 16'h3000;
    cnt(16'h1000);
    cnt(16'h3000);
    cnt(16'h1000);
    irq_is(1'b1, 3'h7);
    svc(16'h8000);
    close_out;
  end
endmodule // tb
